//--- include/codec_rec_pkg.sv
// package with register map, field layout and control structs for the playback-2 / record control bank
// How it works
// - play2_master_sel 0 makes play2 clocks inputs, 1 drives them out
// - play2 gain code maps 0 to -100dB in 0.5dB steps, 0xC8 is 0dB
// - a play2 gain write with apply bit 0 only stores the value
// - apply bit 1 stores and applies both play2 gains together
// - global enable 0 holds converters and ramp control disabled
// - rec_frame_format selects right, left, I2S or DSP framing
// - rec_word_length selects 16/20/24/32 bits, 32 not in right justified
// - rec_bitclk_polarity 1 inverts record bit clock, latching on falling edge
// - rec_frameclk_polarity 1 inverts the record frame clock
// - rec_channel_swap 1 exchanges left and right record slots
// - each record invert bit inverts that channel output
// - record data select routes normal, mono left, mono right or reversed
// - rec_highpass_off 1 bypasses the record high-pass filter
// - rec_zero_cross_en 1 defers record gain changes to zero crossing
// - rec_bitclk_rate selects MCLK/4, MCLK/8, 32, 64, 128fs in master mode
// - rec_master_sel 0 makes record clocks inputs, 1 drives them out
// - record gain 0 mutes, 1 is -97dB, 0xC3 is 0dB, 0xFF +30dB
// - record gain write stores, apply bit 1 applies both record gains
package codec_rec_pkg;

    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_PLAY2_CLK  = 5'h09;
    localparam logic [4:0] IDX_PLAY2_LVOL = 5'h0A;
    localparam logic [4:0] IDX_PLAY2_RVOL = 5'h0B;
    localparam logic [4:0] IDX_ENABLE     = 5'h0C;
    localparam logic [4:0] IDX_REC_CTRL   = 5'h0D;
    localparam logic [4:0] IDX_REC_RATIO  = 5'h0E;
    localparam logic [4:0] IDX_REC_CLK    = 5'h0F;
    localparam logic [4:0] IDX_REC_LVOL   = 5'h10;
    localparam logic [4:0] IDX_REC_RVOL   = 5'h11;
    localparam int         ADDR_LSB       = 2;

    // implemented-bit masks and reset values
    localparam logic [15:0] MASK_BIT0   = 16'h0001;
    localparam logic [15:0] MASK_VOL    = 16'h01FF;
    localparam logic [15:0] MASK_ENABLE = 16'h0003;
    localparam logic [15:0] MASK_RCTRL  = 16'h3FFF;
    localparam logic [15:0] MASK_RATIO  = 16'h003F;
    localparam logic [15:0] RST_PLAY2_VOL = 16'h00C8;
    localparam logic [15:0] RST_REC_VOL   = 16'h00C3;
    localparam logic [15:0] RST_RCTRL     = 16'h200A;
    localparam logic [15:0] RST_ZERO      = 16'h0000;

    // field positions
    localparam int POS_APPLY   = 8;
    localparam int POS_COPY    = 1;
    localparam int POS_FMT     = 0;
    localparam int POS_WL      = 2;
    localparam int POS_BCP     = 4;
    localparam int POS_LRP     = 5;
    localparam int POS_REC_EN  = 6;
    localparam int POS_SWAP    = 7;
    localparam int POS_RINV    = 8;
    localparam int POS_LINV    = 9;
    localparam int POS_DSEL    = 10;
    localparam int POS_HPD     = 12;
    localparam int POS_ZC      = 13;
    localparam int POS_SR      = 0;
    localparam int POS_BCLKDIV = 3;

    // encodings
    localparam logic [1:0] FMT_RJ     = 2'h0;
    localparam logic [1:0] WL_32      = 2'h3;
    localparam logic [2:0] SR_RES1    = 3'h1;
    localparam logic [2:0] SR_RES2    = 3'h2;
    localparam logic [2:0] SR_RES7    = 3'h7;
    localparam logic [2:0] BCLK_MAX   = 3'h4;
    localparam logic [1:0] DSEL_NORM  = 2'h0;
    localparam logic [1:0] DSEL_MONOL = 2'h1;
    localparam logic [1:0] DSEL_MONOR = 2'h2;
    localparam logic [1:0] DSEL_REV   = 2'h3;
    localparam logic [7:0] PLAY2_GAIN_CAP = 8'hE0;
    localparam logic [7:0] REC_MUTE_CODE  = 8'h00;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_e;

    // record serial settings carried to the record converter
    typedef struct packed {
        logic [1:0] frame_format;
        logic [1:0] word_length;
        logic       bitclk_polarity;
        logic       frameclk_polarity;
        logic       channel_swap;
        logic       left_invert;
        logic       right_invert;
        logic [1:0] data_select;
        logic       highpass_off;
        logic       zero_cross_en;
        logic [2:0] clock_ratio;
        logic [2:0] bitclk_rate;
    } rec_cfg_s;

    // applied gain pair
    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
    } gain_pair_s;

endpackage

//--- rtl/codec_play2_rec_regs.sv
// register bank for the second playback converter and the record converter, wishbone classic slave
`timescale 1ns/1ns
`default_nettype none
module codec_play2_rec_regs
    import codec_rec_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_ARST_N,
    input  wire logic [ADDR_W-1:0] I_WB_ADR,
    input  wire logic [31:0]       I_WB_DAT,
    input  wire logic [3:0]        I_WB_SEL,
    input  wire logic              I_WB_WE,
    input  wire logic              I_WB_CYC,
    input  wire logic              I_WB_STB,
    output logic [31:0]            O_WB_DAT,
    output logic                   O_WB_ACK,
    output logic                   O_WB_ERR,
    input  wire logic              I_PLAY1_MASTER_SEL,
    output logic                   O_PLAY2_MASTER_SEL,
    output logic                   O_PLAY2_CLK_OE,
    output logic                   O_PLAY2_COPY_CFG,
    output gain_pair_s             O_PLAY2_GAIN,
    output logic                   O_GLOBAL_EN,
    output logic                   O_REC_EN,
    output rec_cfg_s               O_REC_CFG,
    output logic                   O_REC_CFG_ERR,
    output logic                   O_REC_MASTER_SEL,
    output logic                   O_REC_CLK_OE,
    output logic                   O_REC_BCLK_DIV_EN,
    output gain_pair_s             O_REC_GAIN,
    output logic                   O_REC_LEFT_MUTE,
    output logic                   O_REC_RIGHT_MUTE
);

    logic       rst_meta;
    logic       rst_sync_n;
    bus_state_e state;
    bus_state_e next_state;
    logic [15:0] r_play2_clk;
    logic [15:0] r_play2_lvol;
    logic [15:0] r_play2_rvol;
    logic [15:0] r_enable;
    logic [15:0] r_rec_ctrl;
    logic [15:0] r_rec_ratio;
    logic [15:0] r_rec_clk;
    logic [15:0] r_rec_lvol;
    logic [15:0] r_rec_rvol;
    gain_pair_s  play2_gain;
    gain_pair_s  rec_gain;
    logic [31:0] rdata;

    // reset release through two flops
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // bus decode
    wire               req      = I_WB_CYC && I_WB_STB && (state == BUS_IDLE);
    wire [4:0]         idx      = 5'(I_WB_ADR >> ADDR_LSB);
    wire               aligned  = (I_WB_ADR[ADDR_LSB-1:0] == '0) && (ADDR_W <= 7 || (I_WB_ADR >> 7) == '0);
    wire               hit      = aligned && (idx >= IDX_PLAY2_CLK) && (idx <= IDX_REC_RVOL);
    wire               wr       = req && I_WB_WE && hit;
    wire [15:0]        lane_m   = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    wire [15:0]        wdat     = I_WB_DAT[15:0];
    wire               wr_p2l   = wr && idx == IDX_PLAY2_LVOL;
    wire               wr_p2r   = wr && idx == IDX_PLAY2_RVOL;
    wire               wr_rl    = wr && idx == IDX_REC_LVOL;
    wire               wr_rr    = wr && idx == IDX_REC_RVOL;

    // merged write value, keeping unimplemented bits at zero
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
        merge = ((old & ~lane_m) | (wdat & lane_m)) & msk;
    endfunction

    wire [15:0] new_p2l = merge(r_play2_lvol, MASK_VOL);
    wire [15:0] new_p2r = merge(r_play2_rvol, MASK_VOL);
    wire [15:0] new_rl  = merge(r_rec_lvol, MASK_VOL);
    wire [15:0] new_rr  = merge(r_rec_rvol, MASK_VOL);
    // apply strobes: apply bit set in the written value
    wire apply_p2 = (wr_p2l && new_p2l[POS_APPLY]) || (wr_p2r && new_p2r[POS_APPLY]);
    wire apply_rec = (wr_rl && new_rl[POS_APPLY]) || (wr_rr && new_rr[POS_APPLY]);

    // bus handshake: ack one cycle after request, then idle
    always_comb
    begin
        next_state = state;
        case (state)
            BUS_IDLE: next_state = (I_WB_CYC && I_WB_STB) ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  next_state = BUS_IDLE;
            default:  next_state = BUS_IDLE;
        endcase
    end

    // register storage, defaults on reset
    always_ff @(posedge I_CLK_SYS or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state        <= BUS_IDLE;
            r_play2_clk  <= RST_ZERO;
            r_play2_lvol <= RST_PLAY2_VOL;
            r_play2_rvol <= RST_PLAY2_VOL;
            r_enable     <= RST_ZERO;
            r_rec_ctrl   <= RST_RCTRL;
            r_rec_ratio  <= RST_ZERO;
            r_rec_clk    <= RST_ZERO;
            r_rec_lvol   <= RST_REC_VOL;
            r_rec_rvol   <= RST_REC_VOL;
        end
        else
        begin
            state <= next_state;
            if (wr && idx == IDX_PLAY2_CLK) r_play2_clk <= merge(r_play2_clk, MASK_BIT0);
            if (wr_p2l) r_play2_lvol <= new_p2l;
            if (wr_p2r) r_play2_rvol <= new_p2r;
            if (wr && idx == IDX_ENABLE) r_enable <= merge(r_enable, MASK_ENABLE);
            if (wr && idx == IDX_REC_CTRL) r_rec_ctrl <= merge(r_rec_ctrl, MASK_RCTRL);
            if (wr && idx == IDX_REC_RATIO) r_rec_ratio <= merge(r_rec_ratio, MASK_RATIO);
            if (wr && idx == IDX_REC_CLK) r_rec_clk <= merge(r_rec_clk, MASK_BIT0);
            if (wr_rl) r_rec_lvol <= new_rl;
            if (wr_rr) r_rec_rvol <= new_rr;
        end
    end

    // applied gains move only on an apply write, both channels at once
    always_ff @(posedge I_CLK_SYS or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            play2_gain <= {RST_PLAY2_VOL[7:0], RST_PLAY2_VOL[7:0]};
            rec_gain   <= {RST_REC_VOL[7:0], RST_REC_VOL[7:0]};
        end
        else
        begin
            if (apply_p2)
                play2_gain <= {wr_p2l ? new_p2l[7:0] : r_play2_lvol[7:0],
                               wr_p2r ? new_p2r[7:0] : r_play2_rvol[7:0]};
            if (apply_rec)
                rec_gain <= {wr_rl ? new_rl[7:0] : r_rec_lvol[7:0],
                             wr_rr ? new_rr[7:0] : r_rec_rvol[7:0]};
        end
    end

    // read mux; unmapped or unimplemented reads zero
    always_comb
    begin
        rdata = '0;
        case (idx)
            IDX_PLAY2_CLK:  rdata[15:0] = r_play2_clk;
            IDX_PLAY2_LVOL: rdata[15:0] = r_play2_lvol;
            IDX_PLAY2_RVOL: rdata[15:0] = r_play2_rvol;
            IDX_ENABLE:     rdata[15:0] = r_enable;
            IDX_REC_CTRL:   rdata[15:0] = r_rec_ctrl;
            IDX_REC_RATIO:  rdata[15:0] = r_rec_ratio;
            IDX_REC_CLK:    rdata[15:0] = r_rec_clk;
            IDX_REC_LVOL:   rdata[15:0] = r_rec_lvol;
            IDX_REC_RVOL:   rdata[15:0] = r_rec_rvol;
            default:        rdata = '0;
        endcase
        if (!hit)
            rdata = '0;
    end

    // registered bus answer
    always_ff @(posedge I_CLK_SYS or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            O_WB_ACK <= 1'b0;
            O_WB_ERR <= 1'b0;
            O_WB_DAT <= '0;
        end
        else
        begin
            O_WB_ACK <= req && hit;
            O_WB_ERR <= req && !hit; // unmapped address
            O_WB_DAT <= (req && !I_WB_WE) ? rdata : '0;
        end
    end

    // playback-2 clock direction, copying the first converter when asked
    assign O_PLAY2_COPY_CFG   = r_enable[POS_COPY];
    assign O_PLAY2_MASTER_SEL = O_PLAY2_COPY_CFG ? I_PLAY1_MASTER_SEL : r_play2_clk[0];
    assign O_PLAY2_CLK_OE     = O_PLAY2_MASTER_SEL;
    assign O_PLAY2_GAIN       = play2_gain;

    // enables
    assign O_GLOBAL_EN = r_enable[0];
    assign O_REC_EN    = r_enable[0] && r_rec_ctrl[POS_REC_EN];

    // record serial configuration fields, one driver for the whole struct
    assign O_REC_CFG = '{
        frame_format:      r_rec_ctrl[POS_FMT +: 2],
        word_length:       r_rec_ctrl[POS_WL +: 2],
        bitclk_polarity:   r_rec_ctrl[POS_BCP],
        frameclk_polarity: r_rec_ctrl[POS_LRP],
        channel_swap:      r_rec_ctrl[POS_SWAP],
        left_invert:       r_rec_ctrl[POS_LINV],
        right_invert:      r_rec_ctrl[POS_RINV],
        data_select:       r_rec_ctrl[POS_DSEL +: 2],
        highpass_off:      r_rec_ctrl[POS_HPD],
        zero_cross_en:     r_rec_ctrl[POS_ZC],
        clock_ratio:       r_rec_ratio[POS_SR +: 3],
        bitclk_rate:       r_rec_ratio[POS_BCLKDIV +: 3]
    };

    // illegal settings flagged: 32-bit right justified, reserved ratio, or reserved rate in master mode
    wire [2:0] sr_code = r_rec_ratio[POS_SR +: 3];
    assign O_REC_CFG_ERR = (O_REC_CFG.frame_format == FMT_RJ && O_REC_CFG.word_length == WL_32)
                         || sr_code == SR_RES1 || sr_code == SR_RES2 || sr_code == SR_RES7
                         || (O_REC_MASTER_SEL && O_REC_CFG.bitclk_rate > BCLK_MAX);

    // record clock direction and divider use
    assign O_REC_MASTER_SEL  = r_rec_clk[0];
    assign O_REC_CLK_OE      = r_rec_clk[0];
    assign O_REC_BCLK_DIV_EN = r_rec_clk[0] && O_REC_EN;
    assign O_REC_GAIN        = rec_gain;
    assign O_REC_LEFT_MUTE   = rec_gain.left == REC_MUTE_CODE;
    assign O_REC_RIGHT_MUTE  = rec_gain.right == REC_MUTE_CODE;

    // applied gain holds unless an apply write happens
    AST_GAIN_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        !apply_p2 |=> $stable(play2_gain)) else $error("play2 gain moved without apply");
    AST_GAIN_APPLY: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        (wr_p2l && new_p2l[POS_APPLY]) |=> play2_gain.left == r_play2_lvol[7:0]
        && play2_gain.right == r_play2_rvol[7:0]) else $error("play2 apply mismatch");
    AST_REC_APPLY: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        (wr_rr && new_rr[POS_APPLY]) |=> rec_gain.right == r_rec_rvol[7:0]
        && rec_gain.left == r_rec_lvol[7:0]) else $error("record apply mismatch");
    AST_REC_EN: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        O_REC_EN |-> O_GLOBAL_EN && r_rec_ctrl[POS_REC_EN]) else $error("record enabled while off");
    AST_RESERVED_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        O_WB_ACK |-> O_WB_DAT[31:14] == '0) else $error("reserved bits read nonzero");
    sequence s_req;
        I_WB_CYC && I_WB_STB && state == BUS_IDLE && hit;
    endsequence
    AST_ACK_ONE: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        s_req |=> O_WB_ACK ##1 !O_WB_ACK) else $error("ack not single cycle");
    AST_MASTER_OE: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        (wr && idx == IDX_REC_CLK && I_WB_SEL[0]) |=> O_REC_CLK_OE == $past(I_WB_DAT[0]))
        else $error("record clocks not driven");
    // record applied gains hold unless an apply write happens
    AST_REC_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        !apply_rec |=> $stable(rec_gain)) else $error("record gain moved without apply");
    // read data bus stays quiet outside an acknowledge
    AST_DAT_QUIET: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        !O_WB_ACK |-> O_WB_DAT == '0) else $error("read data outside ack");
    // global enable off keeps the record path and its divider off
    AST_ENABLE_OFF: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        !O_GLOBAL_EN |-> !O_REC_EN && !O_REC_BCLK_DIV_EN) else $error("enabled while global off");
    // without copy the playback-2 clock direction is its own bit
    AST_PLAY2_OWN: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        !O_PLAY2_COPY_CFG |-> O_PLAY2_MASTER_SEL == r_play2_clk[0]) else $error("own master not used");
    AST_COPY: assert property (@(posedge I_CLK_SYS) disable iff (!rst_sync_n)
        O_PLAY2_COPY_CFG |-> O_PLAY2_MASTER_SEL == I_PLAY1_MASTER_SEL) else $error("copy not followed");

endmodule
`default_nettype wire

//--- verif/codec_dac2_adc_ctrl_regs_test.sv
// self-checking testbench for the playback-2 and record control register bank
`timescale 1ns/1ns
`default_nettype none
module codec_dac2_adc_ctrl_regs_test;
    import codec_rec_pkg::*;

    logic        clk;
    logic        arst_n;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
    logic        play1_ms;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic        play2_ms;
    logic        play2_oe;
    logic        copy;
    logic        glob;
    logic        rec_en;
    logic        cfg_err;
    logic        rec_ms;
    logic        rec_oe;
    logic        div_en;
    logic        lmute;
    logic        rmute;
    gain_pair_s  play2_gain;
    gain_pair_s  rec_gain;
    rec_cfg_s    rec_cfg;
    int          fail_count;
    int          checks;

    // reset values and implemented bits of indices 0x09 to 0x11
    localparam logic [15:0] RST_TAB [9] = '{16'h0000, 16'h00C8, 16'h00C8, 16'h0000, 16'h200A,
                                            16'h0000, 16'h0000, 16'h00C3, 16'h00C3};
    localparam logic [15:0] MSK_TAB [9] = '{16'h0001, 16'h01FF, 16'h01FF, 16'h0003, 16'h3FFF,
                                            16'h003F, 16'h0001, 16'h01FF, 16'h01FF};

    codec_play2_rec_regs codec_play2_rec_regs_inst (
        .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel),
        .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_WB_ERR(err),
        .I_PLAY1_MASTER_SEL(play1_ms), .O_PLAY2_MASTER_SEL(play2_ms), .O_PLAY2_CLK_OE(play2_oe),
        .O_PLAY2_COPY_CFG(copy), .O_PLAY2_GAIN(play2_gain), .O_GLOBAL_EN(glob), .O_REC_EN(rec_en),
        .O_REC_CFG(rec_cfg), .O_REC_CFG_ERR(cfg_err), .O_REC_MASTER_SEL(rec_ms), .O_REC_CLK_OE(rec_oe),
        .O_REC_BCLK_DIV_EN(div_en), .O_REC_GAIN(rec_gain), .O_REC_LEFT_MUTE(lmute), .O_REC_RIGHT_MUTE(rmute)
    );

    // 250 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // prints the counts and the verdict, then stops
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // compares one value and reports a difference
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic wishbone cycle, held until ack or err is sampled high
    task automatic bus(input logic w, input logic [4:0] idx, input logic [15:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {1'b0, idx, 2'b00};
        wdat <= {16'h0000, d};
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
            begin
                check("bus answer", 32'h1, 32'h0);
                close_out();
            end
        end
        while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'b1, idx, d, q, e);
        check("write err", 32'h0, {31'h0, e});
    endtask

    task automatic rdchk(input string what, input logic [4:0] idx, input logic [15:0] exp);
        logic [31:0] q;
        logic        e;
        bus(1'b0, idx, 16'h0000, q, e);
        check(what, {16'h0000, exp}, q);
    endtask

    // asynchronous reset, first request sampled on the fifth edge after release
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // defaults of every register and of the applied gains
    task automatic defaults_scn();
        for (int i = 0; i < 9; i++)
            rdchk("reset value", 5'h09 + 5'(i), RST_TAB[i]);
        check("play2 gain", 32'h0000C8C8, {16'h0000, play2_gain});
        check("rec gain", 32'h0000C3C3, {16'h0000, rec_gain});
    endtask

    // all ones written; only implemented bits read back, unmapped index refused
    task automatic ones_scn();
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 9; i++)
            wr(5'h09 + 5'(i), 16'hFFFF);
        for (int i = 0; i < 9; i++)
            rdchk("masked readback", 5'h09 + 5'(i), MSK_TAB[i]);
        bus(1'b1, 5'h12, 16'hFFFF, q, e);
        check("unmapped err", 32'h1, {31'h0, e});
        check("rec cfg ones", 32'h0007FFFF, {13'h0, rec_cfg});
        check("gains applied", 32'hFFFFFFFF, {play2_gain, rec_gain});
        check("div enable", 32'h1, {31'h0, div_en});
    endtask

    // stored gains wait for the apply bit, then both sides change together
    task automatic gain_scn();
        wr(IDX_PLAY2_LVOL, 16'h0010);
        check("play2 held", 32'h0000C8C8, {16'h0000, play2_gain});
        wr(IDX_PLAY2_RVOL, 16'h0120);
        check("play2 applied", 32'h00001020, {16'h0000, play2_gain});
        wr(IDX_REC_LVOL, 16'h0000);
        check("rec held", 32'h0000C3C3, {16'h0000, rec_gain});
        wr(IDX_REC_RVOL, 16'h01FF);
        check("rec applied", 32'h000000FF, {16'h0000, rec_gain});
        check("mutes", 32'h2, {30'h0, lmute, rmute});
    endtask

    // enables, clock directions and the copy option
    task automatic enable_scn();
        wr(IDX_ENABLE, 16'h0001);
        check("rec en off", 32'h2, {30'h0, glob, rec_en});
        wr(IDX_REC_CTRL, 16'h204A);
        check("rec en on", 32'h3, {30'h0, glob, rec_en});
        wr(IDX_ENABLE, 16'h0000);
        check("global off", 32'h0, {30'h0, glob, rec_en});
        wr(IDX_PLAY2_CLK, 16'h0001);
        check("play2 master", 32'h3, {30'h0, play2_ms, play2_oe});
        wr(IDX_REC_CLK, 16'h0001);
        check("rec master", 32'h6, {29'h0, rec_ms, rec_oe, div_en});
        wr(IDX_ENABLE, 16'h0002);
        wr(IDX_PLAY2_CLK, 16'h0000);
        play1_ms <= 1'b1;
        @(posedge clk);
        check("copy master", 32'h3, {30'h0, copy, play2_ms});
        wr(IDX_ENABLE, 16'h0000);
        check("own master", 32'h0, {30'h0, copy, play2_ms});
    endtask

    // format, routing, ratio and rate codes with their error flags
    task automatic cfg_scn();
        for (int f = 0; f < 4; f++)
        begin
            wr(IDX_REC_CTRL, 16'(f * 1024 + 12 + f));
            check("format", 32'(f), {30'h0, rec_cfg.frame_format});
            check("routing", 32'(f), {30'h0, rec_cfg.data_select});
            check("rj 32 err", {31'h0, f == 0}, {31'h0, cfg_err});
        end
        for (int r = 0; r < 8; r++)
        begin
            wr(IDX_REC_RATIO, 16'(32 + r));
            check("ratio", 32'(r), {29'h0, rec_cfg.clock_ratio});
            check("ratio err", {31'h0, r == 1 || r == 2 || r == 7}, {31'h0, cfg_err});
        end
        wr(IDX_REC_RATIO, 16'h002B);
        check("rate err", 32'h1, {31'h0, cfg_err});
        wr(IDX_REC_CLK, 16'h0000);
        check("rate slave", 32'h0, {31'h0, cfg_err});
        wr(IDX_REC_CTRL, 16'h1330);
        check("misc bits", 32'h0000006E, {25'h0, rec_cfg.bitclk_polarity, rec_cfg.frameclk_polarity,
              rec_cfg.channel_swap, rec_cfg.left_invert, rec_cfg.right_invert, rec_cfg.highpass_off,
              rec_cfg.zero_cross_en});
    endtask

    // main sequence
    initial
    begin
        fail_count = 0;
        checks = 0;
        arst_n = 1'b0;
        adr = 8'h00;
        wdat = 32'h00000000;
        sel = 4'h3;
        we = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        play1_ms = 1'b0;
        do_reset();
        defaults_scn();
        ones_scn();
        do_reset();
        defaults_scn();
        gain_scn();
        enable_scn();
        cfg_scn();
        close_out();
    end
endmodule
`default_nettype wire
